/* design/ces_pkg.sv */
// Constants for the processor error status register bank.
// Assumes a 32-bit classic Wishbone slave; each 64-bit register is two words.
package ces_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADR_IFES_LO = 8'h00;
  localparam logic [7:0] ADR_IFES_HI = 8'h04;
  localparam logic [7:0] ADR_MMFS_LO = 8'h08;
  localparam logic [7:0] ADR_MMFS_HI = 8'h0C;
  localparam logic [7:0] ADR_DCES_LO = 8'h10;
  localparam logic [7:0] ADR_DCES_HI = 8'h14;
  localparam logic [7:0] ADR_VA_LO = 8'h18;
  localparam logic [7:0] ADR_VA_HI = 8'h1C;
  // Instruction fetch status fields
  localparam int unsigned IF_DPE_BIT = 30;
  localparam int unsigned IF_TPE_BIT = 29;
  // Memory management fault status fields
  localparam int unsigned MM_TAGP_BIT = 10;
  localparam int unsigned MM_OP_LSB = 4;
  localparam int unsigned MM_OP_W = 6;
  localparam int unsigned MM_FOW_BIT = 3;
  localparam int unsigned MM_FOR_BIT = 2;
  localparam int unsigned MM_ACV_BIT = 1;
  localparam int unsigned MM_WR_BIT = 0;
  localparam logic [5:0] OP_HW_LOAD = 6'h03;
  localparam logic [5:0] OP_HW_STORE = 6'h07;
  // Data cache status fields
  localparam int unsigned DC_SEO_BIT = 4;
  localparam int unsigned DC_LD_BIT = 3;
  localparam int unsigned DC_ST_BIT = 2;
  localparam int unsigned DC_P1_BIT = 1;
  localparam int unsigned DC_P0_BIT = 0;
  localparam int unsigned DC_W = 5;
  localparam logic [2:0] SEO_WINDOW = 3'h6;
  localparam logic [31:0] RD_NONE = 32'h0000_0000;
endpackage : ces_pkg

/* design/ces_status_regs.sv */
// Processor error status register bank: fetch, memory management and data cache.
// Assumes event inputs are single-cycle pulses from core logic on clk_i.
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ces_status_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ces_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ic_data_perr_i,
  input wire logic ic_tag_perr_i,
  input wire logic dtb_event_i,
  input wire logic dtb_pte_load_i,
  input wire logic dc_probe_tag_perr_i,
  input wire logic [5:0] dtb_opcode_i,
  input wire logic dtb_fow_i,
  input wire logic dtb_for_i,
  input wire logic dtb_acv_i,
  input wire logic dtb_write_i,
  input wire logic [63:0] dtb_va_i,
  input wire logic dc_ecc_load_i,
  input wire logic dc_ecc_store_i,
  input wire logic dcache_tag_probe_parity_flag_p1_i,
  input wire logic dcache_tag_probe_parity_flag_p0_i,
  output logic data_fault_o,
  output logic machine_check_o
);
  typedef struct packed {
    logic [1:0] ifes;
    logic [10:0] mmfs;
    logic [63:0] va;
    logic [ces_pkg::DC_W-1:0] dces;
    logic [2:0] seo_cnt;
    logic [31:0] dat;
    logic ack;
    logic dfault;
    logic mchk;
  } ces_state_s;

  ces_state_s st_reg, st_next;
  logic req;
  logic wr0;
  logic [63:0] ifes_full, mmfs_full, dces_full;

  assign req = wb_cyc_i && wb_stb_i && !st_reg.ack;
  assign wr0 = req && wb_we_i && wb_sel_i[0];

  always_comb begin
    ifes_full = '0;
    ifes_full[ces_pkg::IF_DPE_BIT] = st_reg.ifes[1];
    ifes_full[ces_pkg::IF_TPE_BIT] = st_reg.ifes[0];
    mmfs_full = {53'h0, st_reg.mmfs};
    dces_full = {59'h0, st_reg.dces};
  end

  always_comb begin
    logic [ces_pkg::DC_W-1:0] dc_clr;
    logic [1:0] if_clr;
    logic [31:0] wd;
    dc_clr = '0;
    if_clr = '0;
    wd = wb_dat_i;
    st_next = st_reg;
    st_next.ack = req;
    st_next.dfault = 1'b0;
    // Write one to clear; writes to reserved or read-only bits are dropped
    if (req && wb_we_i && wb_sel_i[3] && wb_adr_i == ces_pkg::ADR_IFES_LO) begin
      if_clr = {wd[ces_pkg::IF_DPE_BIT], wd[ces_pkg::IF_TPE_BIT]};
    end
    if (wr0 && wb_adr_i == ces_pkg::ADR_DCES_LO) begin
      dc_clr = wd[ces_pkg::DC_W-1:0];
    end
    // Set wins over clear in the same cycle
    st_next.ifes[1] = (st_reg.ifes[1] & ~if_clr[1]) | ic_data_perr_i;
    st_next.ifes[0] = (st_reg.ifes[0] & ~if_clr[0]) | ic_tag_perr_i;
    st_next.dces = st_reg.dces & ~dc_clr;
    st_next.dces[ces_pkg::DC_LD_BIT] = st_next.dces[ces_pkg::DC_LD_BIT] | dc_ecc_load_i;
    st_next.dces[ces_pkg::DC_ST_BIT] = st_next.dces[ces_pkg::DC_ST_BIT] | dc_ecc_store_i;
    st_next.dces[ces_pkg::DC_P1_BIT] = st_next.dces[ces_pkg::DC_P1_BIT] | dcache_tag_probe_parity_flag_p1_i;
    st_next.dces[ces_pkg::DC_P0_BIT] = st_next.dces[ces_pkg::DC_P0_BIT] | dcache_tag_probe_parity_flag_p0_i;
    // Window counter runs after each store ECC error
    if (dc_ecc_store_i) begin
      if (st_reg.seo_cnt != 3'h0) begin
        st_next.dces[ces_pkg::DC_SEO_BIT] = 1'b1;
      end
      st_next.seo_cnt = ces_pkg::SEO_WINDOW;
    end else if (st_reg.seo_cnt != 3'h0) begin
      st_next.seo_cnt = st_reg.seo_cnt - 3'h1;
    end
    // Machine check held while either pipe tag flag stands
    st_next.mchk = st_next.dces[ces_pkg::DC_P1_BIT] | st_next.dces[ces_pkg::DC_P0_BIT];
    // Translation path: read-only, updated by hardware only
    if (dtb_event_i && !dtb_pte_load_i) begin
      st_next.mmfs[ces_pkg::MM_TAGP_BIT] = dc_probe_tag_perr_i;
      st_next.mmfs[ces_pkg::MM_OP_LSB +: ces_pkg::MM_OP_W] = dtb_opcode_i;
      st_next.mmfs[ces_pkg::MM_FOW_BIT] = dtb_fow_i & dtb_write_i;
      st_next.mmfs[ces_pkg::MM_FOR_BIT] = dtb_for_i & ~dtb_write_i;
      st_next.mmfs[ces_pkg::MM_ACV_BIT] = dtb_acv_i;
      st_next.mmfs[ces_pkg::MM_WR_BIT] = dtb_write_i;
      st_next.va = dtb_va_i;
      st_next.dfault = dc_probe_tag_perr_i;
    end
    // Read mux; unmapped offsets read zero and still ack
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        ces_pkg::ADR_IFES_LO: st_next.dat = ifes_full[31:0];
        ces_pkg::ADR_IFES_HI: st_next.dat = ifes_full[63:32];
        ces_pkg::ADR_MMFS_LO: st_next.dat = mmfs_full[31:0];
        ces_pkg::ADR_MMFS_HI: st_next.dat = mmfs_full[63:32];
        ces_pkg::ADR_DCES_LO: st_next.dat = dces_full[31:0];
        ces_pkg::ADR_DCES_HI: st_next.dat = dces_full[63:32];
        ces_pkg::ADR_VA_LO: st_next.dat = st_reg.va[31:0];
        ces_pkg::ADR_VA_HI: st_next.dat = st_reg.va[63:32];
        default: st_next.dat = ces_pkg::RD_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_o = st_reg.dat;
  assign wb_ack_o = st_reg.ack;
  assign data_fault_o = st_reg.dfault;
  assign machine_check_o = st_reg.mchk;

  // Checks share one clock; the window bound must be a local int
  localparam int seo_span = int'(ces_pkg::SEO_WINDOW);
  logic mm_capture;
  assign mm_capture = dtb_event_i && !dtb_pte_load_i;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_fetch_dpe_set: assert property (
    ic_data_perr_i
    |=> st_reg.ifes[1]
  ) else $error("fetch data parity flag not set");

  chk_fetch_tpe_set: assert property (
    ic_tag_perr_i
    |=> st_reg.ifes[0]
  ) else $error("fetch tag parity flag not set");

  chk_fetch_dpe_idle: assert property (
    !st_reg.ifes[1] && !ic_data_perr_i
    |=> !st_reg.ifes[1]
  ) else $error("fetch data parity flag set without error");

  chk_fetch_tpe_idle: assert property (
    !st_reg.ifes[0] && !ic_tag_perr_i
    |=> !st_reg.ifes[0]
  ) else $error("fetch tag parity flag set without error");

  chk_fetch_w1c: assert property (
    req && wb_we_i && wb_sel_i[3] && wb_adr_i == ces_pkg::ADR_IFES_LO && wb_dat_i[ces_pkg::IF_DPE_BIT] && !ic_data_perr_i
    |=> !st_reg.ifes[1]
  ) else $error("fetch data parity flag not cleared");

  chk_fetch_tpe_w1c: assert property (
    req && wb_we_i && wb_sel_i[3] && wb_adr_i == ces_pkg::ADR_IFES_LO && wb_dat_i[ces_pkg::IF_TPE_BIT] && !ic_tag_perr_i
    |=> !st_reg.ifes[0]
  ) else $error("fetch tag parity flag not cleared");

  chk_fetch_dpe_keep: assert property (
    st_reg.ifes[1] && !(req && wb_we_i && wb_sel_i[3] && wb_adr_i == ces_pkg::ADR_IFES_LO && wb_dat_i[ces_pkg::IF_DPE_BIT])
    |=> st_reg.ifes[1]
  ) else $error("fetch data parity flag lost");

  chk_fetch_tpe_keep: assert property (
    st_reg.ifes[0] && !(req && wb_we_i && wb_sel_i[3] && wb_adr_i == ces_pkg::ADR_IFES_LO && wb_dat_i[ces_pkg::IF_TPE_BIT])
    |=> st_reg.ifes[0]
  ) else $error("fetch tag parity flag lost");

  chk_mm_pte_hold: assert property (
    dtb_pte_load_i || !dtb_event_i
    |=> $stable(st_reg.mmfs)
  ) else $error("mm status changed");

  chk_mm_va_hold: assert property (
    dtb_pte_load_i || !dtb_event_i
    |=> $stable(st_reg.va)
  ) else $error("virtual address changed");

  chk_mm_read_only: assert property (
    req && wb_we_i && !mm_capture
    |=> $stable(st_reg.mmfs)
  ) else $error("mm status written by bus");

  chk_mm_tagp_bit: assert property (
    mm_capture
    |=> st_reg.mmfs[ces_pkg::MM_TAGP_BIT] == $past(dc_probe_tag_perr_i)
  ) else $error("probe parity bit wrong");

  chk_mm_opcode: assert property (
    mm_capture
    |=> st_reg.mmfs[ces_pkg::MM_OP_LSB +: ces_pkg::MM_OP_W] == $past(dtb_opcode_i)
  ) else $error("opcode wrong");

  chk_mm_fow_bit: assert property (
    mm_capture
    |=> st_reg.mmfs[ces_pkg::MM_FOW_BIT] == $past(dtb_fow_i && dtb_write_i)
  ) else $error("fault on write bit wrong");

  chk_mm_for_bit: assert property (
    mm_capture
    |=> st_reg.mmfs[ces_pkg::MM_FOR_BIT] == $past(dtb_for_i && !dtb_write_i)
  ) else $error("fault on read bit wrong");

  chk_mm_acv_bit: assert property (
    mm_capture
    |=> st_reg.mmfs[ces_pkg::MM_ACV_BIT] == $past(dtb_acv_i)
  ) else $error("access violation bit wrong");

  chk_mm_write_bit: assert property (
    mm_capture
    |=> st_reg.mmfs[ces_pkg::MM_WR_BIT] == $past(dtb_write_i)
  ) else $error("write bit wrong");

  chk_mm_va_capture: assert property (
    mm_capture
    |=> st_reg.va == $past(dtb_va_i)
  ) else $error("virtual address not captured");

  chk_dc_fault_pulse: assert property (
    mm_capture && dc_probe_tag_perr_i
    |=> data_fault_o && st_reg.mmfs[ces_pkg::MM_TAGP_BIT]
  ) else $error("data fault missing");

  chk_fault_needs_probe: assert property (
    !(mm_capture && dc_probe_tag_perr_i)
    |=> !data_fault_o
  ) else $error("data fault without probe error");

  chk_va_read_lo: assert property (
    req && !wb_we_i && wb_adr_i == ces_pkg::ADR_VA_LO
    |=> wb_dat_o == $past(st_reg.va[31:0])
  ) else $error("virtual address read wrong");

  chk_dc_ld_set: assert property (
    dc_ecc_load_i
    |=> st_reg.dces[ces_pkg::DC_LD_BIT]
  ) else $error("load ecc flag not set");

  chk_dc_st_set: assert property (
    dc_ecc_store_i
    |=> st_reg.dces[ces_pkg::DC_ST_BIT]
  ) else $error("store ecc flag not set");

  chk_dc_keep: assert property (
    st_reg.dces[ces_pkg::DC_ST_BIT] && !(wr0 && wb_adr_i == ces_pkg::ADR_DCES_LO && wb_dat_i[ces_pkg::DC_ST_BIT])
    |=> st_reg.dces[ces_pkg::DC_ST_BIT]
  ) else $error("store ecc flag lost");

  chk_dc_w1c: assert property (
    wr0 && wb_adr_i == ces_pkg::ADR_DCES_LO && wb_dat_i[ces_pkg::DC_LD_BIT] && !dc_ecc_load_i
    |=> !st_reg.dces[ces_pkg::DC_LD_BIT]
  ) else $error("load ecc flag not cleared");

  chk_seo_window: assert property (
    dc_ecc_store_i ##[1:seo_span] dc_ecc_store_i
    |=> st_reg.dces[ces_pkg::DC_SEO_BIT]
  ) else $error("second store error missed");

  chk_seo_quiet: assert property (
    !st_reg.dces[ces_pkg::DC_SEO_BIT] && dc_ecc_store_i && st_reg.seo_cnt == 3'h0 && !wr0
    |=> !st_reg.dces[ces_pkg::DC_SEO_BIT]
  ) else $error("second store flag set early");

  chk_dc_p0_mchk: assert property (
    dcache_tag_probe_parity_flag_p0_i
    |=> st_reg.dces[ces_pkg::DC_P0_BIT] && machine_check_o
  ) else $error("pipe 0 machine check missing");

  chk_dc_p1_mchk: assert property (
    dcache_tag_probe_parity_flag_p1_i
    |=> st_reg.dces[ces_pkg::DC_P1_BIT] && machine_check_o
  ) else $error("pipe 1 machine check missing");

  chk_mchk_clear: assert property (
    wr0 && wb_adr_i == ces_pkg::ADR_DCES_LO && wb_dat_i[ces_pkg::DC_P0_BIT] && wb_dat_i[ces_pkg::DC_P1_BIT]
    && !dcache_tag_probe_parity_flag_p0_i && !dcache_tag_probe_parity_flag_p1_i |=> !machine_check_o
  ) else $error("machine check stuck after clear");

  chk_ifes_lo_resv: assert property (
    req && !wb_we_i && wb_adr_i == ces_pkg::ADR_IFES_LO
    |=> wb_dat_o[ces_pkg::IF_TPE_BIT-1:0] == '0
  ) else $error("fetch status reserved bits set");

  chk_ifes_hi_zero: assert property (
    req && !wb_we_i && wb_adr_i == ces_pkg::ADR_IFES_HI
    |=> wb_dat_o == ces_pkg::RD_NONE
  ) else $error("fetch status high word not zero");

  chk_mmfs_hi_zero: assert property (
    req && !wb_we_i && wb_adr_i == ces_pkg::ADR_MMFS_HI
    |=> wb_dat_o == ces_pkg::RD_NONE
  ) else $error("mm status high word not zero");

  chk_dces_resv: assert property (
    req && !wb_we_i && wb_adr_i == ces_pkg::ADR_DCES_LO
    |=> wb_dat_o[31:ces_pkg::DC_W] == '0
  ) else $error("data cache status reserved bits set");

  chk_dces_hi_zero: assert property (
    req && !wb_we_i && wb_adr_i == ces_pkg::ADR_DCES_HI
    |=> wb_dat_o == ces_pkg::RD_NONE
  ) else $error("data cache status high word not zero");

  chk_unmapped_zero: assert property (
    req && !wb_we_i && wb_adr_i > ces_pkg::ADR_VA_HI
    |=> wb_dat_o == ces_pkg::RD_NONE
  ) else $error("unmapped word not zero");

  chk_bus_ack_follows: assert property (
    req
    |=> wb_ack_o
  ) else $error("ack missing");

  chk_bus_ack_idle: assert property (
    !req
    |=> !wb_ack_o
  ) else $error("ack without request");

  chk_bus_ack_once: assert property (
    wb_ack_o
    |=> !wb_ack_o
  ) else $error("ack held two cycles");

  cov_seo: cover property (
    $rose(st_reg.dces[ces_pkg::DC_SEO_BIT])
  );

  cov_fault: cover property (
    data_fault_o
  );

  cov_clear: cover property (
    $fell(st_reg.ifes[1])
  );

  cov_pte_skip: cover property (
    dtb_event_i && dtb_pte_load_i
  );

  cov_mchk: cover property (
    $rose(machine_check_o)
  );
endmodule : ces_status_regs
`default_nettype wire

/* tb/ces_status_regs_tb.sv */
// Self-checking bench for the processor error status register bank.
// Assumes a registered one-cycle Wishbone ack and single-cycle event pulses.
`timescale 1ns/1ps
`default_nettype none
module ces_status_regs_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ces_pkg::ADDR_W-1:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic data_fault_o;
  logic machine_check_o;
  logic [6:0] ev = 7'h00;
  logic [11:0] qual = 12'h000;
  logic [63:0] dtb_va_i = 64'h0000_0000_0000_0000;
  logic [31:0] q;
  int error_cnt = 0;
  int comparisons = 0;
  int fault_cnt = 0;

  ces_status_regs dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .ic_data_perr_i(ev[0]), .ic_tag_perr_i(ev[1]), .dtb_event_i(ev[2]),
    .dtb_pte_load_i(qual[0]), .dc_probe_tag_perr_i(qual[1]), .dtb_opcode_i(qual[11:6]), .dtb_fow_i(qual[5]),
    .dtb_for_i(qual[4]), .dtb_acv_i(qual[3]), .dtb_write_i(qual[2]), .dtb_va_i, .dc_ecc_load_i(ev[3]),
    .dc_ecc_store_i(ev[4]), .dcache_tag_probe_parity_flag_p1_i(ev[5]), .dcache_tag_probe_parity_flag_p0_i(ev[6]), .data_fault_o,
    .machine_check_o);

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // Counts fault pulses so a stuck or doubled pulse shows up
  always @(posedge clk_i) begin
    if (data_fault_o === 1'b1) fault_cnt++;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Holds the request until ack is sampled high; no fixed latency assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, s, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0000_0000, 4'hF);
    chk(nm, q, e);
  endtask : rd

  task automatic fire(input logic [6:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 7'h00;
  endtask : fire

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (3000) @(posedge clk_i);
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // Last pass hits an unmapped word
    for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0000_0000, "reset word");
    $display("test reset done");
    fire(7'h01);
    rd(ces_pkg::ADR_IFES_LO, 32'h4000_0000, "fetch data parity");
    fire(7'h02);
    rd(ces_pkg::ADR_IFES_LO, 32'h6000_0000, "fetch tag parity");
    wb(1'b1, ces_pkg::ADR_IFES_LO, 32'h4000_0000, 4'hF);
    rd(ces_pkg::ADR_IFES_LO, 32'h2000_0000, "fetch clear one");
    wb(1'b1, ces_pkg::ADR_IFES_LO, 32'h9FFF_FFFF, 4'hF);
    rd(ces_pkg::ADR_IFES_LO, 32'h2000_0000, "fetch zero keeps");
    wb(1'b1, ces_pkg::ADR_IFES_LO, 32'hFFFF_FFFF, 4'hF);
    rd(ces_pkg::ADR_IFES_LO, 32'h0000_0000, "fetch cleared");
    $display("test fetch done");
    // Hardware load, read, violation, probe parity error
    qual <= 12'h0DA;
    dtb_va_i <= 64'h1234_5678_9ABC_DEF0;
    fire(7'h04);
    rd(ces_pkg::ADR_MMFS_LO, 32'h0000_0436, "mm load fault");
    rd(ces_pkg::ADR_VA_LO, 32'h9ABC_DEF0, "va low");
    rd(ces_pkg::ADR_VA_HI, 32'h1234_5678, "va high");
    chk("fault pulses", 32'(fault_cnt), 32'h0000_0001);
    // Hardware store with fault on write
    qual <= 12'h1E4;
    fire(7'h04);
    rd(ces_pkg::ADR_MMFS_LO, 32'h0000_0079, "mm store fault");
    // Page table entry load must not disturb the capture
    qual <= 12'h149;
    fire(7'h04);
    rd(ces_pkg::ADR_MMFS_LO, 32'h0000_0079, "mm pte load");
    wb(1'b1, ces_pkg::ADR_MMFS_LO, 32'hFFFF_FFFF, 4'hF);
    rd(ces_pkg::ADR_MMFS_LO, 32'h0000_0079, "mm read only");
    rd(ces_pkg::ADR_MMFS_HI, 32'h0000_0000, "mm high word");
    chk("fault pulses", 32'(fault_cnt), 32'h0000_0001);
    $display("test translation done");
    fire(7'h08);
    rd(ces_pkg::ADR_DCES_LO, 32'h0000_0008, "dc load ecc");
    fire(7'h10);
    rd(ces_pkg::ADR_DCES_LO, 32'h0000_000C, "dc single store");
    wb(1'b1, ces_pkg::ADR_DCES_LO, 32'hFFFF_FFFF, 4'hF);
    fire(7'h10);
    fire(7'h10);
    rd(ces_pkg::ADR_DCES_LO, 32'h0000_0014, "dc second store");
    fire(7'h20);
    rd(ces_pkg::ADR_DCES_LO, 32'h0000_0016, "dc pipe one");
    chk("machine check", {31'h0000_0000, machine_check_o}, 32'h0000_0001);
    wb(1'b1, ces_pkg::ADR_DCES_LO, 32'h0000_0016, 4'hF);
    fire(7'h40);
    rd(ces_pkg::ADR_DCES_LO, 32'h0000_0001, "dc pipe zero");
    chk("machine check", {31'h0000_0000, machine_check_o}, 32'h0000_0001);
    wb(1'b1, ces_pkg::ADR_DCES_LO, 32'hFFFF_FFFF, 4'hF);
    rd(ces_pkg::ADR_DCES_LO, 32'h0000_0000, "dc cleared");
    chk("machine check", {31'h0000_0000, machine_check_o}, 32'h0000_0000);
    $display("test data cache done");
    conclude();
  end
endmodule : ces_status_regs_tb
`default_nettype wire
